// file: switch_forwarding_config_regs.sv
// Purpose: unknown-destination routing, phy address select and per-port ingress enables
// Assumes: register port on clk; one access per cycle; a read in a write cycle returns the old value
// Notes: outputs update on the same edge that stores the written byte
`include "switch_forwarding_defines.svh"

module switch_forwarding_config_regs
   import switch_forwarding_pkg::*;
#(
   parameter int NUM_PORTS = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire reg_byte_t reg_addr,
   input wire reg_byte_t reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output reg_byte_t reg_rdata,
   output port_mask_t unknown_da_ports,
   output logic unknown_da_redirect,
   output phy_addr_t phy1_addr,
   output phy_addr_t phy2_addr,
   output logic phy_addr_valid,
   output logic [NUM_PORTS-1:0] storm_protect_en,
   output logic [NUM_PORTS-1:0] diffserv_en
);
   reg_byte_t unknown_ctrl;
   reg_byte_t next_unknown_ctrl;
   phy_addr_t next_phy1_addr;
   phy_addr_t next_phy2_addr;
   logic next_phy_addr_valid;
   port_mask_t next_unknown_da_ports;
   logic next_unknown_da_redirect;
   reg_byte_t next_reg_rdata;
   logic [NUM_PORTS-1:0] port_write;
   reg_byte_t port_ctrl [NUM_PORTS];
   logic [NUM_PORTS-1:0] next_storm_protect_en;
   logic [NUM_PORTS-1:0] next_diffserv_en;

   localparam reg_byte_t PORT_ADDR [3] = '{`ADDR_PORT1_CTRL, `ADDR_PORT2_CTRL, `ADDR_PORT3_CTRL};

   // per-port control registers, one instance each
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_write[p] = reg_we && (reg_addr == PORT_ADDR[p]);
      port_ingress_reg #(
         .RESET_VALUE(`PORT_CTRL_RESET)
      ) u_port (
         .clk(clk),
         .reset(reset),
         .write(port_write[p]),
         .wdata(reg_wdata),
         .ctrl(port_ctrl[p])
      );
   end

   // next values of the global registers and derived forwarding outputs
   always_comb begin
      next_unknown_ctrl = unknown_ctrl;
      next_phy1_addr = phy1_addr;
      if (reg_we && reg_addr == `ADDR_UNKNOWN_FWD) begin
         next_unknown_ctrl = reg_wdata;
      end
      if (reg_we && reg_addr == `ADDR_PHY_SELECT) begin
         next_phy1_addr = reg_wdata[`PHY_ADDR_MSB:`PHY_ADDR_LSB];
      end
      next_phy2_addr = phy_addr_t'(next_phy1_addr + `PHY_ADDR_STEP);
      next_phy_addr_valid = (next_phy1_addr != `PHY_ADDR_NA_LOW) && (next_phy1_addr != `PHY_ADDR_NA_HIGH0)
         && (next_phy1_addr != `PHY_ADDR_NA_HIGH1);
      next_unknown_da_redirect = next_unknown_ctrl[`UNKNOWN_EN_BIT];
      // redirect off: flood to all ports, mask ignored
      if (next_unknown_ctrl[`UNKNOWN_EN_BIT]) begin
         next_unknown_da_ports = next_unknown_ctrl[`UNKNOWN_MASK_MSB:0];
      end else begin
         next_unknown_da_ports = `ALL_PORTS_MASK;
      end
   end

   // per-port enables, taken from the value the port register will hold
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         next_storm_protect_en[p] = port_write[p] ? reg_wdata[`STORM_EN_BIT] : port_ctrl[p][`STORM_EN_BIT];
         next_diffserv_en[p] = port_write[p] ? reg_wdata[`DIFFSERV_EN_BIT] : port_ctrl[p][`DIFFSERV_EN_BIT];
      end
   end

   // read decode; reserved phy bits read as zero, unmapped offsets read zero
   always_comb begin
      next_reg_rdata = reg_rdata;
      if (reg_re) begin
         next_reg_rdata = `READ_UNMAPPED;
         if (reg_addr == `ADDR_UNKNOWN_FWD) begin
            next_reg_rdata = unknown_ctrl;
         end
         if (reg_addr == `ADDR_PHY_SELECT) begin
            next_reg_rdata = {phy1_addr, `PHY_RSVD_VALUE};
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (reg_addr == PORT_ADDR[p]) begin
               next_reg_rdata = port_ctrl[p];
            end
         end
      end
   end

   // register stage
   always_ff @(posedge clk) begin
      if (reset) begin
         unknown_ctrl <= `UNKNOWN_FWD_RESET;
         phy1_addr <= `PHY_ADDR_RESET;
         phy2_addr <= phy_addr_t'(`PHY_ADDR_RESET + `PHY_ADDR_STEP);
         phy_addr_valid <= 1'b1;
         unknown_da_ports <= `ALL_PORTS_MASK;
         unknown_da_redirect <= 1'b0;
         storm_protect_en <= '0;
         diffserv_en <= '0;
         reg_rdata <= `READ_UNMAPPED;
      end else begin
         unknown_ctrl <= next_unknown_ctrl;
         phy1_addr <= next_phy1_addr;
         phy2_addr <= next_phy2_addr;
         phy_addr_valid <= next_phy_addr_valid;
         unknown_da_ports <= next_unknown_da_ports;
         unknown_da_redirect <= next_unknown_da_redirect;
         storm_protect_en <= next_storm_protect_en;
         diffserv_en <= next_diffserv_en;
         reg_rdata <= next_reg_rdata;
      end
   end

   // access sequences used by the checks
   sequence s_wr_unknown;
      reg_we && reg_addr == `ADDR_UNKNOWN_FWD;
   endsequence
   sequence s_rd_unknown;
      reg_re && !reg_we && reg_addr == `ADDR_UNKNOWN_FWD;
   endsequence
   sequence s_rd_phy;
      reg_re && reg_addr == `ADDR_PHY_SELECT;
   endsequence

   a_unknown_redirect: assert property (@(posedge clk) disable iff (reset)
      unknown_da_ports == (unknown_ctrl[`UNKNOWN_EN_BIT] ? unknown_ctrl[2:0] : 3'h7))
      else $error("unknown destination ports do not follow enable and mask");
   a_mask_reset: assert property (@(posedge clk)
      reset |=> unknown_ctrl[2:0] == 3'h7 && unknown_da_ports == 3'h7 && !unknown_da_redirect)
      else $error("unknown destination mask not all ports after reset");
   a_phy_reserved: assert property (@(posedge clk) disable iff (reset)
      s_rd_phy |=> reg_rdata[2:0] == 3'h0)
      else $error("reserved phy select bits read nonzero");
   a_phy_valid: assert property (@(posedge clk) disable iff (reset)
      phy_addr_valid == !(phy1_addr == 5'h00 || phy1_addr == 5'h1e || phy1_addr == 5'h1f))
      else $error("phy address valid flag wrong");
   a_phy2_offset: assert property (@(posedge clk) disable iff (reset)
      phy2_addr == phy_addr_t'(phy1_addr + 5'h01))
      else $error("port 2 phy address is not port 1 plus one");
   a_port2_decode: assert property (@(posedge clk) disable iff (reset)
      (reg_we && reg_addr == 8'h20) |=> storm_protect_en[1] == $past(reg_wdata[7])
      && $stable(storm_protect_en[0]) && $stable(storm_protect_en[2]))
      else $error("port 2 control decode wrong");
   a_storm_enable: assert property (@(posedge clk) disable iff (reset)
      (reg_we && reg_addr == 8'h10) |=> storm_protect_en[0] == $past(reg_wdata[7]))
      else $error("port 1 storm enable not taken from bit 7");
   a_diffserv_enable: assert property (@(posedge clk) disable iff (reset)
      (reg_we && reg_addr == 8'h30) |=> diffserv_en[2] == $past(reg_wdata[6]))
      else $error("port 3 diffserv enable not taken from bit 6");
   a_unknown_readback: assert property (@(posedge clk) disable iff (reset)
      s_wr_unknown ##1 s_rd_unknown |=> reg_rdata == $past(reg_wdata, 2))
      else $error("unknown forwarding register does not read back");

   // further access shapes for the decode, readback and hold checks
   sequence s_wr_phy;
      reg_we && reg_addr == `ADDR_PHY_SELECT;
   endsequence
   sequence s_rw_unknown;
      reg_we && reg_re && reg_addr == `ADDR_UNKNOWN_FWD;
   endsequence
   sequence s_rd_port2;
      reg_re && !reg_we && reg_addr == `ADDR_PORT2_CTRL;
   endsequence
   sequence s_rd_unmapped;
      reg_re && reg_addr != `ADDR_UNKNOWN_FWD && reg_addr != `ADDR_PHY_SELECT && reg_addr != `ADDR_PORT1_CTRL
         && reg_addr != `ADDR_PORT2_CTRL && reg_addr != `ADDR_PORT3_CTRL;
   endsequence
   sequence s_no_port_wr;
      !(reg_we && (reg_addr == `ADDR_PORT1_CTRL || reg_addr == `ADDR_PORT2_CTRL
         || reg_addr == `ADDR_PORT3_CTRL));
   endsequence
   sequence s_no_unknown_wr;
      !(reg_we && reg_addr == `ADDR_UNKNOWN_FWD);
   endsequence

   // outputs only move on a write to their own register, read data only on a read
   a_redirect_write: assert property (@(posedge clk) disable iff (reset)
      s_wr_unknown |=> unknown_da_redirect == $past(reg_wdata[`UNKNOWN_EN_BIT]))
      else $error("redirect enable not taken from bit 7");
   a_unknown_hold: assert property (@(posedge clk) disable iff (reset)
      s_no_unknown_wr |=> $stable(unknown_da_ports) && $stable(unknown_da_redirect))
      else $error("unknown destination outputs changed without a write");
   a_phy_write: assert property (@(posedge clk) disable iff (reset)
      s_wr_phy |=> phy1_addr == $past(reg_wdata[`PHY_ADDR_MSB:`PHY_ADDR_LSB]))
      else $error("phy address not taken from bits 7 to 3");
   a_config_reset: assert property (@(posedge clk)
      reset |=> phy1_addr == `PHY_ADDR_RESET && phy2_addr == phy_addr_t'(`PHY_ADDR_RESET + `PHY_ADDR_STEP)
      && phy_addr_valid && storm_protect_en == '0 && diffserv_en == '0 && reg_rdata == `READ_UNMAPPED)
      else $error("configuration outputs not at reset values");
   a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
      s_rd_unmapped |=> reg_rdata == `READ_UNMAPPED)
      else $error("unmapped offset does not read zero");
   a_port2_readback: assert property (@(posedge clk) disable iff (reset)
      s_rd_port2 |=> reg_rdata[`STORM_EN_BIT] == $past(storm_protect_en[1])
      && reg_rdata[`DIFFSERV_EN_BIT] == $past(diffserv_en[1]))
      else $error("port 2 control readback disagrees with its enables");
   a_port_hold: assert property (@(posedge clk) disable iff (reset)
      s_no_port_wr |=> $stable(storm_protect_en) && $stable(diffserv_en))
      else $error("port enables changed without a port write");
   a_port1_diffserv: assert property (@(posedge clk) disable iff (reset)
      (reg_we && reg_addr == `ADDR_PORT1_CTRL) |=> diffserv_en[0] == $past(reg_wdata[`DIFFSERV_EN_BIT]))
      else $error("port 1 diffserv enable not taken from bit 6");
   a_port3_storm: assert property (@(posedge clk) disable iff (reset)
      (reg_we && reg_addr == `ADDR_PORT3_CTRL) |=> storm_protect_en[2] == $past(reg_wdata[`STORM_EN_BIT]))
      else $error("port 3 storm enable not taken from bit 7");
   a_rw_old_value: assert property (@(posedge clk) disable iff (reset)
      s_rw_unknown |=> reg_rdata == $past(unknown_ctrl))
      else $error("read in a write cycle did not return the old value");
   a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
      !reg_re |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule : switch_forwarding_config_regs

// file: switch_forwarding_defines.svh
// Purpose: offsets, field positions and reset values of the switch forwarding configuration registers
// Assumes: byte-wide management register map with eight-bit offsets
// Notes: definitions only; included by the package users
`ifndef SWITCH_FORWARDING_DEFINES_SVH
`define SWITCH_FORWARDING_DEFINES_SVH

`define ADDR_UNKNOWN_FWD 8'h0e
`define ADDR_PHY_SELECT 8'h0f
`define ADDR_PORT1_CTRL 8'h10
`define ADDR_PORT2_CTRL 8'h20
`define ADDR_PORT3_CTRL 8'h30

`define UNKNOWN_EN_BIT 7
`define UNKNOWN_MASK_MSB 2
`define UNKNOWN_RSVD_MSB 6
`define UNKNOWN_RSVD_LSB 3
`define UNKNOWN_FWD_RESET 8'h07

`define PHY_ADDR_MSB 7
`define PHY_ADDR_LSB 3
`define PHY_ADDR_RESET 5'h01
`define PHY_ADDR_NA_LOW 5'h00
`define PHY_ADDR_NA_HIGH0 5'h1e
`define PHY_ADDR_NA_HIGH1 5'h1f
`define PHY_ADDR_STEP 5'h01
`define PHY_RSVD_VALUE 3'h0

`define STORM_EN_BIT 7
`define DIFFSERV_EN_BIT 6
`define PORT_CTRL_RESET 8'h00

`define ALL_PORTS_MASK 3'h7
`define READ_UNMAPPED 8'h00

`endif

// file: switch_forwarding_pkg.sv
// Purpose: shared types of the switch forwarding configuration block
// Assumes: three switch ports
// Notes: constants live in switch_forwarding_defines.svh
package switch_forwarding_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [4:0] phy_addr_t;
   typedef logic [2:0] port_mask_t;
endpackage : switch_forwarding_pkg

// file: port_ingress_reg.sv
// Purpose: one per-port ingress control register, same layout for every port
// Assumes: write strobe already decoded for this port's offset
// Notes: bits 5..0 are stored for readback only
module port_ingress_reg
   import switch_forwarding_pkg::*;
#(
   parameter reg_byte_t RESET_VALUE = 8'h00
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic write,
   input wire reg_byte_t wdata,
   output reg_byte_t ctrl
);
   reg_byte_t next_ctrl;

   // next value: take the written byte, else hold
   always_comb begin
      next_ctrl = ctrl;
      if (write) begin
         next_ctrl = wdata;
      end
   end

   // register stage with synchronous reset
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= RESET_VALUE;
      end else begin
         ctrl <= next_ctrl;
      end
   end
endmodule : port_ingress_reg

// file: switch_forwarding_config_regs_tb.sv
// Purpose: self-checking bench for the forwarding configuration registers
// Assumes: inputs change at the falling edge; read data is valid one cycle after the strobe
// Notes: no partner model, the bench drives the register port itself
module switch_forwarding_config_regs_tb
   import switch_forwarding_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   reg_byte_t reg_addr = 8'h00;
   reg_byte_t reg_wdata = 8'h00;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   reg_byte_t reg_rdata;
   port_mask_t unknown_da_ports;
   logic unknown_da_redirect;
   phy_addr_t phy1_addr;
   phy_addr_t phy2_addr;
   logic phy_addr_valid;
   logic [2:0] storm_protect_en;
   logic [2:0] diffserv_en;
   int err_total = 0;
   int comparisons = 0;
   reg_byte_t rv;
   switch_forwarding_config_regs #(.NUM_PORTS(3)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .unknown_da_ports(unknown_da_ports), .unknown_da_redirect(unknown_da_redirect), .phy1_addr(phy1_addr),
      .phy2_addr(phy2_addr), .phy_addr_valid(phy_addr_valid), .storm_protect_en(storm_protect_en),
      .diffserv_en(diffserv_en));
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // one write strobe, released at the next falling edge
   task automatic wr(input reg_byte_t addr, input reg_byte_t data);
      @(negedge clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_we = 1'b1;
      @(negedge clk);
      reg_we = 1'b0;
   endtask : wr
   // one read strobe; data is taken a cycle later
   task automatic rd(input reg_byte_t addr, output reg_byte_t data);
      @(negedge clk);
      reg_addr = addr;
      reg_re = 1'b1;
      @(negedge clk);
      reg_re = 1'b0;
      data = reg_rdata;
   endtask : rd
   // write, then read the same offset in the very next cycle
   task automatic wr_rd(input reg_byte_t addr, input reg_byte_t data, output reg_byte_t rdata);
      @(negedge clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_we = 1'b1;
      @(negedge clk);
      reg_we = 1'b0;
      reg_re = 1'b1;
      @(negedge clk);
      reg_re = 1'b0;
      rdata = reg_rdata;
   endtask : wr_rd
   // write and read of one offset in the same cycle
   task automatic wr_with_rd(input reg_byte_t addr, input reg_byte_t data, output reg_byte_t rdata);
      @(negedge clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_we = 1'b1;
      reg_re = 1'b1;
      @(negedge clk);
      reg_we = 1'b0;
      reg_re = 1'b0;
      rdata = reg_rdata;
   endtask : wr_with_rd
   task automatic test_reset_values();
      rd(8'h0e, rv); chk("fwd reg", rv, 8'h07);
      rd(8'h0f, rv); chk("phy reg", rv, 8'h08);
      for (int p = 1; p <= 3; p++) begin
         rd(8'(p << 4), rv); chk("port reg", rv, 8'h00);
      end
      chk("ports", {5'h0, unknown_da_ports}, 8'h07);
      chk("redirect", {7'h0, unknown_da_redirect}, 8'h00);
      chk("phy1", {3'h0, phy1_addr}, 8'h01);
      chk("phy valid", {7'h0, phy_addr_valid}, 8'h01);
      chk("phy2", {3'h0, phy2_addr}, 8'h02);
      chk("enables", {2'h0, storm_protect_en, diffserv_en}, 8'h00);
      $display("reset values done");
   endtask : test_reset_values
   task automatic test_redirect();
      for (int m = 0; m < 8; m++) begin
         wr(8'h0e, 8'h80 | 8'(m));
         chk("ports on", {5'h0, unknown_da_ports}, 8'(m));
         chk("redirect on", {7'h0, unknown_da_redirect}, 8'h01);
         wr(8'h0e, 8'(m));
         chk("ports off", {5'h0, unknown_da_ports}, 8'h07);
         chk("redirect off", {7'h0, unknown_da_redirect}, 8'h00);
         rd(8'h0e, rv); chk("fwd readback", rv, 8'(m));
      end
      wr(8'h0e, 8'h07);
      $display("redirect done");
   endtask : test_redirect
   task automatic test_phy_address();
      logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h10, 5'h1d, 5'h1e, 5'h1f};
      foreach (codes[i]) begin
         wr(8'h0f, {codes[i], 3'h0});
         rd(8'h0f, rv); chk("phy readback", rv, {codes[i], 3'h0});
         chk("phy1", {3'h0, phy1_addr}, {3'h0, codes[i]});
         chk("phy2", {3'h0, phy2_addr}, {3'h0, 5'(codes[i] + 5'h01)});
         chk("phy valid", {7'h0, phy_addr_valid}, 8'(codes[i] != 5'h00 && codes[i] < 5'h1e));
      end
      wr(8'h0f, 8'h08);
      $display("phy address done");
   endtask : test_phy_address
   task automatic test_port_controls();
      for (int p = 0; p < 3; p++) begin
         wr(8'((p + 1) << 4), 8'h80);
         chk("storm", {5'h0, storm_protect_en}, 8'(1 << p));
         chk("diffserv off", {5'h0, diffserv_en}, 8'h00);
         wr(8'((p + 1) << 4), 8'h7f);
         chk("diffserv", {5'h0, diffserv_en}, 8'(1 << p));
         chk("storm off", {5'h0, storm_protect_en}, 8'h00);
         rd(8'((p + 1) << 4), rv); chk("port readback", rv, 8'h7f);
         wr(8'((p + 1) << 4), 8'h00);
      end
      wr(8'h11, 8'hff);
      rd(8'h11, rv); chk("unmapped read", rv, 8'h00);
      chk("unmapped write", {2'h0, storm_protect_en, diffserv_en}, 8'h00);
      $display("port controls done");
   endtask : test_port_controls
   task automatic test_back_to_back();
      wr_rd(8'h0e, 8'h85, rv); chk("next cycle read", rv, 8'h85);
      chk("ports back to back", {5'h0, unknown_da_ports}, 8'h05);
      wr_with_rd(8'h0e, 8'h07, rv); chk("same cycle read", rv, 8'h85);
      rd(8'h0e, rv); chk("after same cycle", rv, 8'h07);
      wr(8'h10, 8'h40);
      chk("read data stands", reg_rdata, 8'h07);
      chk("port 1 diffserv", {5'h0, diffserv_en}, 8'h01);
      wr(8'h10, 8'h00);
      $display("back to back done");
   endtask : test_back_to_back
   task automatic test_mid_reset();
      wr(8'h0e, 8'h82);
      wr(8'h0f, 8'h50);
      wr(8'h20, 8'hc0);
      chk("storm before reset", {5'h0, storm_protect_en}, 8'h02);
      @(negedge clk);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk("ports after reset", {5'h0, unknown_da_ports}, 8'h07);
      chk("redirect after reset", {7'h0, unknown_da_redirect}, 8'h00);
      chk("phy1 after reset", {3'h0, phy1_addr}, 8'h01);
      chk("phy2 after reset", {3'h0, phy2_addr}, 8'h02);
      chk("enables after reset", {2'h0, storm_protect_en, diffserv_en}, 8'h00);
      rd(8'h20, rv); chk("port 2 after reset", rv, 8'h00);
      rd(8'h0e, rv); chk("fwd after reset", rv, 8'h07);
      $display("mid-run reset done");
   endtask : test_mid_reset
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // main sequence, reset held for five cycles
   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      test_reset_values();
      test_redirect();
      test_phy_address();
      test_port_controls();
      test_back_to_back();
      test_mid_reset();
      give_verdict();
   end
   // watchdog, far beyond the roughly 140 cycles the tests need
   initial begin
      #50us;
      err_total++;
      give_verdict();
   end
endmodule : switch_forwarding_config_regs_tb
